// [core/sddr_ctl.sv]
// controller end: issues user commands on the pins only when legal
// assumes the user holds a request stable until it is acknowledged
module sddr_ctl #(
	parameter int              CNT_W     = 8,
	parameter logic [CNT_W-1:0] RP_CYC    = CNT_W'(`SDDR_RP_CYC),
	parameter logic [CNT_W-1:0] RCD_CYC   = CNT_W'(`SDDR_RCD_CYC),
	parameter logic [CNT_W-1:0] WR_CYC    = CNT_W'(`SDDR_WR_CYC),
	parameter logic [CNT_W-1:0] RC_CYC    = CNT_W'(`SDDR_RC_CYC),
	parameter logic [CNT_W-1:0] MRD_CYC   = CNT_W'(`SDDR_MRD_CYC),
	parameter logic [CNT_W-1:0] BURST_CYC = CNT_W'(`SDDR_BURST_CYC)
) (
	input  wire logic                    clk,
	input  wire logic                    rst,
	sddr_if.ctl                          pins,
	input  wire logic                    req_valid,
	input  sddr_pkg::sddr_cmd_e          req_cmd,
	input  wire logic [1:0]              req_bank,
	input  wire logic [`SDDR_ADDR_W-1:0] req_addr,
	output logic                         req_ack_q
);
	import sddr_pkg::*;

	localparam int NB = `SDDR_BANKS;

	logic [NB-1:0]    open_q;
	logic [NB-1:0]    free_w;
	logic [NB-1:0]    hit_w;
	logic [CNT_W-1:0] gbusy_q;
	logic             ok_w;
	wire logic        ac_w;
	wire logic        issue_w;

	assign ac_w = req_addr[`SDDR_AUTOCLOSE_BIT];

	// legality from the shadow of bank state; busy banks never get
	// a command, so bursts always run to the end
	always_comb begin
		case (req_cmd)
			SDDR_OPEN:
				ok_w = !open_q[req_bank] && free_w[req_bank];
			SDDR_READ, SDDR_WRITE:
				ok_w = open_q[req_bank] && free_w[req_bank];
			SDDR_CLOSE:
				ok_w = &(free_w | ~hit_w);
			SDDR_REFRESH, SDDR_MODE:
				ok_w = (&free_w) && !(|open_q);
			default:
				ok_w = 1'b1;
		endcase
	end

	// the cycle after an ack is skipped so a held request is not reissued
	assign issue_w = req_valid && !req_ack_q && (gbusy_q == '0) && ok_w;

	for (genvar b = 0; b < NB; b++) begin : g_bank
		logic [CNT_W-1:0] busy_q;

		assign free_w[b] = busy_q == '0;
		assign hit_w[b] = (req_bank == 2'(b)) ||
		                  ((req_cmd == SDDR_CLOSE) && ac_w);

		// busy covers the whole transient, so the device is stable again
		always_ff @(posedge clk) begin
			if (rst) begin
				busy_q <= '0;
				open_q[b] <= 1'b0;
			end else if (issue_w && hit_w[b] &&
			             (req_cmd == SDDR_OPEN)) begin
				busy_q <= RCD_CYC;
				open_q[b] <= 1'b1;
			end else if (issue_w && hit_w[b] &&
			             (req_cmd == SDDR_READ)) begin
				busy_q <= ac_w ? CNT_W'(BURST_CYC + RP_CYC)
				               : BURST_CYC;
				open_q[b] <= !ac_w;
			end else if (issue_w && hit_w[b] &&
			             (req_cmd == SDDR_WRITE)) begin
				busy_q <= ac_w ? CNT_W'(BURST_CYC + WR_CYC + RP_CYC)
				               : CNT_W'(BURST_CYC + WR_CYC);
				open_q[b] <= !ac_w;
			end else if (issue_w && hit_w[b] &&
			             (req_cmd == SDDR_CLOSE)) begin
				busy_q <= open_q[b] ? RP_CYC : '0;
				open_q[b] <= 1'b0;
			end else if (busy_q != '0) begin
				busy_q <= busy_q - 1'b1;
			end
		end
	end

	// device-wide wait after refresh or mode set
	always_ff @(posedge clk) begin
		if (rst) begin
			gbusy_q <= '0;
		end else if (issue_w && (req_cmd == SDDR_REFRESH)) begin
			gbusy_q <= RC_CYC;
		end else if (issue_w && (req_cmd == SDDR_MODE)) begin
			gbusy_q <= MRD_CYC;
		end else if (gbusy_q != '0) begin
			gbusy_q <= gbusy_q - 1'b1;
		end
	end

	// pins hold a command for one cycle, then deselect
	always_ff @(posedge clk) begin
		if (rst) begin
			pins.cke <= 1'b1;
			pins.cs_n <= 1'b1;
			{pins.ras_n, pins.cas_n, pins.we_n} <= `SDDR_PAT_NOP;
			pins.bank_sel <= 2'h0;
			pins.addr <= '0;
			req_ack_q <= 1'b0;
		end else begin
			pins.cke <= 1'b1;
			req_ack_q <= issue_w;
			if (issue_w) begin
				pins.cs_n <= req_cmd == SDDR_DESEL;
				{pins.ras_n, pins.cas_n, pins.we_n} <= sddr_pattern(req_cmd);
				pins.bank_sel <= req_bank;
				pins.addr <= req_addr;
			end else begin
				pins.cs_n <= 1'b1;
				{pins.ras_n, pins.cas_n, pins.we_n} <= `SDDR_PAT_NOP;
			end
		end
	end
endmodule

// [core/sddr_dev.sv]
// device end: per-bank state tracking and command legality checking
// assumes pins come from logic on the same clock, so no synchroniser
//
// Notes on behaviour
// - commands decode from select and three strobes
// - autoclose burst runs out; other commands illegal
// - closing bank idles after precharge time unless a close lands on its last cycle
// - opening bank goes active after column delay
// - write recovery returns active; new write allowed
// - autoclose write recovery then enters closing
// - refresh blocks every command for row cycle
// - mode set blocks every command for cycle time
// - busy-bank command may go to another bank
// - refresh and mode set only all idle
// - no burst interrupt at burst length four; the model accepts a same-direction read or write mid-burst
// - interrupt only same direction, four-beat boundary
// - no read-write cross interruption ever
// - close shuts addressed bank, or all banks
// - refresh with clock enable low self-refreshes
module sddr_dev #(
	parameter int              CNT_W     = 8,
	parameter logic [CNT_W-1:0] RP_CYC    = CNT_W'(`SDDR_RP_CYC),
	parameter logic [CNT_W-1:0] RCD_CYC   = CNT_W'(`SDDR_RCD_CYC),
	parameter logic [CNT_W-1:0] WR_CYC    = CNT_W'(`SDDR_WR_CYC),
	parameter logic [CNT_W-1:0] RC_CYC    = CNT_W'(`SDDR_RC_CYC),
	parameter logic [CNT_W-1:0] MRD_CYC   = CNT_W'(`SDDR_MRD_CYC),
	parameter logic [CNT_W-1:0] BURST_CYC = CNT_W'(`SDDR_BURST_CYC)
) (
	input  wire logic              clk,
	input  wire logic              rst,
	sddr_if.dev                    pins,
	output logic                   cmd_illegal_q,
	output logic [`SDDR_BANKS-1:0] bank_fault_q,
	output logic [`SDDR_BANKS-1:0] bank_idle_q,
	output logic                   dev_busy_q,
	output logic                   self_refresh_q
);
	import sddr_pkg::*;

	localparam int NB = `SDDR_BANKS;

	// which commands each bank state accepts when aimed at it
	function automatic logic allowed(sddr_bank_e st, sddr_cmd_e c);
		logic ok;
		ok = 1'b0;
		case (st)
			SDDR_BK_IDLE:
				ok = (c != SDDR_READ) && (c != SDDR_WRITE);
			SDDR_BK_ACTIVE:
				ok = (c == SDDR_READ) || (c == SDDR_WRITE) ||
				     (c == SDDR_CLOSE);
			SDDR_BK_READ:
				ok = (c == SDDR_READ);
			SDDR_BK_WRITE, SDDR_BK_WREC:
				ok = (c == SDDR_WRITE);
			SDDR_BK_CLOSING:
				ok = (c == SDDR_CLOSE);
			default:
				ok = 1'b0;
		endcase
		return ok;
	endfunction

	// device-wide state: refresh, mode set, self refresh
	sddr_glob_e       glob_q;
	sddr_glob_e       glob_d;
	logic [CNT_W-1:0] gcnt_q;
	logic [CNT_W-1:0] gcnt_d;

	// command decode and bank targeting
	sddr_cmd_e        cmd_w;
	wire logic        ac_w;
	wire logic        none_w;
	wire logic        all_w;
	wire logic        glob_busy_w;
	wire logic        illegal_w;
	wire logic        take_w;
	logic [NB-1:0]    hit_w;
	logic [NB-1:0]    ok_w;
	logic [NB-1:0]    idle_d;

	assign cmd_w = sddr_decode(pins.cs_n,
	                           {pins.ras_n, pins.cas_n, pins.we_n});
	assign ac_w = pins.addr[`SDDR_AUTOCLOSE_BIT];
	assign none_w = (cmd_w == SDDR_NOP) || (cmd_w == SDDR_DESEL);
	// refresh and mode set touch every bank, so each must be idle
	assign all_w = (cmd_w == SDDR_REFRESH) || (cmd_w == SDDR_MODE) ||
	               ((cmd_w == SDDR_CLOSE) && ac_w);
	assign glob_busy_w = glob_q != SDDR_GL_IDLE;
	// any non-no-op during refresh, mode set or self refresh is flagged
	assign illegal_w = !none_w &&
	                   (glob_busy_w || |(hit_w & ~ok_w));
	// illegal commands are dropped so they never change bank or device state
	assign take_w = !none_w && !illegal_w;

	// device-wide next state and interval timer
	always_comb begin
		glob_d = glob_q;
		gcnt_d = (gcnt_q != '0) ? gcnt_q - 1'b1 : gcnt_q;
		unique case (glob_q)
			SDDR_GL_IDLE: begin
				if (take_w && (cmd_w == SDDR_REFRESH)) begin
					glob_d = pins.cke ? SDDR_GL_REFRESH : SDDR_GL_SELF;
					gcnt_d = RC_CYC;
				end else if (take_w && (cmd_w == SDDR_MODE)) begin
					glob_d = SDDR_GL_MODE;
					gcnt_d = MRD_CYC;
				end
			end
			SDDR_GL_REFRESH, SDDR_GL_MODE: begin
				if (gcnt_q == CNT_W'(1)) begin
					glob_d = SDDR_GL_IDLE;
				end
			end
			SDDR_GL_SELF: begin
				// exit timing is left to the controller
				if (pins.cke) begin
					glob_d = SDDR_GL_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			glob_q <= SDDR_GL_IDLE;
			gcnt_q <= '0;
		end else begin
			glob_q <= glob_d;
			gcnt_q <= gcnt_d;
		end
	end

	// one tracker per bank
	for (genvar b = 0; b < NB; b++) begin : g_bank
		sddr_bank_e       st_q;
		sddr_bank_e       st_d;
		logic [CNT_W-1:0] cnt_q;
		logic [CNT_W-1:0] cnt_d;

		assign hit_w[b] = !none_w &&
		                  (all_w || (pins.bank_sel == 2'(b)));
		assign ok_w[b] = allowed(st_q, cmd_w);
		assign idle_d[b] = st_d == SDDR_BK_IDLE;

		// a legal open, read or write, or a close of an active bank, restarts the bank; else the timer runs out
		always_comb begin
			st_d = st_q;
			cnt_d = (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
			if (take_w && hit_w[b]) begin
				case (cmd_w)
					SDDR_OPEN: begin
						st_d = SDDR_BK_OPENING;
						cnt_d = RCD_CYC;
					end
					SDDR_READ: begin
						st_d = ac_w ? SDDR_BK_READ_AC : SDDR_BK_READ;
						cnt_d = BURST_CYC;
					end
					SDDR_WRITE: begin
						st_d = ac_w ? SDDR_BK_WRITE_AC : SDDR_BK_WRITE;
						cnt_d = BURST_CYC;
					end
					SDDR_CLOSE: begin
						// closing an idle bank is a no-op; on a closing bank too, unless it lands on the last cycle, which leaves the bank stuck closing
						if (st_q == SDDR_BK_ACTIVE) begin
							st_d = SDDR_BK_CLOSING;
							cnt_d = RP_CYC;
						end
					end
					default: begin
					end
				endcase
			end else if (cnt_q == CNT_W'(1)) begin
				case (st_q)
					SDDR_BK_OPENING, SDDR_BK_READ, SDDR_BK_WREC:
						st_d = SDDR_BK_ACTIVE;
					SDDR_BK_WRITE: begin
						st_d = SDDR_BK_WREC;
						cnt_d = WR_CYC;
					end
					SDDR_BK_WRITE_AC: begin
						st_d = SDDR_BK_WREC_AC;
						cnt_d = WR_CYC;
					end
					SDDR_BK_READ_AC, SDDR_BK_WREC_AC: begin
						st_d = SDDR_BK_CLOSING;
						cnt_d = RP_CYC;
					end
					SDDR_BK_CLOSING:
						st_d = SDDR_BK_IDLE;
					default: begin
					end
				endcase
			end
		end

		always_ff @(posedge clk) begin
			if (rst) begin
				st_q <= SDDR_BK_IDLE;
				cnt_q <= '0;
			end else begin
				st_q <= st_d;
				cnt_q <= cnt_d;
			end
		end
	end

	// registered status, one cycle behind the sampled command
	always_ff @(posedge clk) begin
		if (rst) begin
			cmd_illegal_q <= 1'b0;
			bank_fault_q <= '0;
			bank_idle_q <= '1;
			dev_busy_q <= 1'b0;
			self_refresh_q <= 1'b0;
		end else begin
			cmd_illegal_q <= illegal_w;
			bank_fault_q <= none_w ? '0 : (hit_w & ~ok_w);
			bank_idle_q <= idle_d;
			dev_busy_q <= glob_d != SDDR_GL_IDLE;
			self_refresh_q <= glob_d == SDDR_GL_SELF;
		end
	end
endmodule

// [dv/sddr_properties.sv]
// checker for the command pins between controller and device ends
// assumes default interval counts: refresh 6 cycles, mode set 2, close 2
`include "sddr_defs.svh"
module sddr_properties (
	input wire logic                    clk,
	input wire logic                    rst,
	input wire logic                    cke,
	input wire logic                    cs_n,
	input wire logic                    ras_n,
	input wire logic                    cas_n,
	input wire logic                    we_n,
	input wire logic [1:0]              bank_sel,
	input wire logic [`SDDR_ADDR_W-1:0] addr,
	input wire logic                    req_ack_q,
	input wire logic                    cmd_illegal_q,
	input wire logic [`SDDR_BANKS-1:0]  bank_idle_q,
	input wire logic                    dev_busy_q
);
	// decoded commands; single-bank close of an open bank only
	wire logic [2:0] pat     = {ras_n, cas_n, we_n};
	wire logic       open_c  = !cs_n && pat == `SDDR_PAT_OPEN;
	wire logic       close_c = !cs_n && pat == `SDDR_PAT_CLOSE
		&& !addr[`SDDR_AUTOCLOSE_BIT] && !bank_idle_q[bank_sel];
	wire logic       ref_c   = !cs_n && pat == `SDDR_PAT_REFRESH;
	wire logic       mode_c  = !cs_n && pat == `SDDR_PAT_MODE;

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	chk_never_flagged: assert property (!cmd_illegal_q)
		else $error("controller command flagged illegal");
	chk_ack_one_cmd: assert property (req_ack_q |-> !cs_n ##1 cs_n)
		else $error("acknowledged command not one cycle on pins");
	chk_cmd_has_ack: assert property (!cs_n |-> req_ack_q)
		else $error("command on pins without acknowledge");
	chk_open_not_idle: assert property (
		open_c |=> !bank_idle_q[$past(bank_sel)])
		else $error("opened bank still idle");
	chk_close_span: assert property (
		close_c |=> !bank_idle_q[$past(bank_sel)]
		##1 !bank_idle_q[$past(bank_sel, 2)]
		##1 bank_idle_q[$past(bank_sel, 3)])
		else $error("closed bank idle time wrong");
	chk_refresh_span: assert property (
		ref_c |=> dev_busy_q [*6] ##1 !dev_busy_q)
		else $error("refresh busy span wrong");
	chk_mode_span: assert property (
		mode_c |=> dev_busy_q [*2] ##1 !dev_busy_q)
		else $error("mode set busy span wrong");
	chk_all_idle_first: assert property (
		ref_c || mode_c |-> bank_idle_q == 4'hF)
		else $error("refresh or mode set with a bank open");
	chk_quiet_busy: assert property (
		dev_busy_q |-> cs_n || pat == `SDDR_PAT_NOP)
		else $error("command issued while device busy");
	chk_cke_held: assert property (cke)
		else $error("clock enable dropped");
endmodule

// [dv/sdram_bank_state_command_rules_bench.sv]
// bench: controller and device joined on one link; a second device
// end is fed straight from the bench with deliberately illegal commands
// assumes the default interval counts and burst length of the design
`include "sddr_defs.svh"
module sdram_bank_state_command_rules_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import sddr_pkg::*;

	// pin pattern {row, column, write strobe} by command code
	localparam logic [2:0] PAT [8] = '{3'h7, 3'h7, 3'h5, 3'h4, 3'h3, 3'h2,
		3'h1, 3'h0};
	// injection script {command, bank, autoclose, illegal}, one a cycle;
	// no-ops sit on state boundaries, where legality is left open
	localparam logic [6:0] N0 = {SDDR_NOP, 4'h0};
	localparam logic [6:0] SEQ [37] = '{
		{SDDR_OPEN, 4'h0}, {SDDR_READ, 4'h1}, N0, {SDDR_WRITE, 4'h2},
		{SDDR_OPEN, 4'h1}, {SDDR_OPEN, 4'h4}, {SDDR_READ, 4'h1}, N0,
		{SDDR_CLOSE, 4'h0}, N0, {SDDR_OPEN, 4'h0}, {SDDR_WRITE, 4'h4},
		N0, N0, {SDDR_WRITE, 4'h4}, N0, N0, {SDDR_READ, 4'h5}, N0,
		{SDDR_CLOSE, 4'h2}, {SDDR_READ, 4'h1}, N0, {SDDR_REFRESH, 4'h0},
		{SDDR_OPEN, 4'h9}, {SDDR_MODE, 4'h1}, N0, N0, N0, N0,
		{SDDR_MODE, 4'h0}, {SDDR_OPEN, 4'hD}, N0, {SDDR_OPEN, 4'hC}, N0,
		N0, {SDDR_READ, 4'hE}, {SDDR_WRITE, 4'hD}
	};

	logic                    clk = 1'b0;
	logic                    rst = 1'b1;
	logic                    req_valid = 1'b0;
	sddr_cmd_e               req_cmd = SDDR_NOP;
	logic [1:0]              req_bank = 2'h0;
	logic [`SDDR_ADDR_W-1:0] req_addr = 13'h0000;
	logic                    req_ack_q;
	logic                    ill1;
	logic                    ill2;
	logic [3:0]              flt2;
	logic                    sr2;
	logic [1:0]              q_bnk [$];
	logic                    busy1;
	logic [3:0]              idle1;
	logic                    due2 = 1'b0;
	int                      n_fail = 0;
	int                      checks = 0;
	int                      cycles = 0;
	int                      seed = 84506;
	logic [5:0]              q_pins [$];
	logic                    q_ill [$];

	sddr_if p1 (.clk(clk));
	sddr_if p2 (.clk(clk));

	sddr_ctl sddr_ctl_i (.clk(clk), .rst(rst), .pins(p1.ctl),
		.req_valid(req_valid), .req_cmd(req_cmd), .req_bank(req_bank),
		.req_addr(req_addr), .req_ack_q(req_ack_q));
	sddr_dev sddr_dev_i (.clk(clk), .rst(rst), .pins(p1.dev),
		.cmd_illegal_q(ill1), .bank_fault_q(), .bank_idle_q(idle1),
		.dev_busy_q(busy1), .self_refresh_q());
	sddr_dev sddr_dev_x_i (.clk(clk), .rst(rst), .pins(p2.dev),
		.cmd_illegal_q(ill2), .bank_fault_q(flt2), .bank_idle_q(),
		.dev_busy_q(), .self_refresh_q(sr2));
	sddr_properties sddr_properties_i (.clk(clk), .rst(rst), .cke(p1.cke),
		.cs_n(p1.cs_n), .ras_n(p1.ras_n), .cas_n(p1.cas_n), .we_n(p1.we_n),
		.bank_sel(p1.bank_sel), .addr(p1.addr), .req_ack_q(req_ack_q),
		.cmd_illegal_q(ill1), .bank_idle_q(idle1), .dev_busy_q(busy1));

	always #5 clk = ~clk;

	task automatic end_sim();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic cmp_pins(input logic [5:0] e, input logic [5:0] g);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR pins expected %h seen %h", e, g);
		end
	endtask

	task automatic cmp_flag(input logic e, input logic g);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR illegal_flag expected %b seen %b", e, g);
		end
	endtask

	// one user request, held until acknowledged; the note goes first
	task automatic req(input sddr_cmd_e c, input logic [1:0] b,
		input logic a);
		q_pins.push_back({PAT[c], b, a});
		@(posedge clk);
		req_cmd <= c;
		req_bank <= b;
		req_addr <= {2'h0, a, 10'($random(seed))};
		req_valid <= 1'b1;
		repeat (40) begin
			@(posedge clk);
			if (req_ack_q === 1'b1) break;
		end
		req_valid <= 1'b0;
	endtask

	// every command cycle on the joined link takes the oldest note
	always @(negedge clk) begin
		if (!rst && p1.cs_n === 1'b0) begin
			cmp_pins(q_pins.size() > 0 ? q_pins.pop_front() : 6'hXX,
				{p1.ras_n, p1.cas_n, p1.we_n, p1.bank_sel, p1.addr[10]});
		end
	end

	// flag of the injected device is due one edge after each command
	always @(posedge clk) due2 <= (p2.cs_n === 1'b0);
	always @(negedge clk) begin
		if (due2) begin
			cmp_flag(q_ill.pop_front(), ill2);
			// a fault may only blame the addressed bank, or all of them
			cmp_flag(1'b0, |(flt2 & ~(4'h1 << q_bnk.pop_front()))
				&& !(&flt2));
			cmp_flag(1'b0, sr2);
		end
	end

	// hang guard, far beyond the fewer than two hundred cycles the run needs
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_fail++;
			end_sim();
		end
	end

	// reset, then the controller and the injection script side by side
	initial begin
		logic [1:0] b;
		logic [6:0] s;
		p2.cke = 1'b1;
		p2.cs_n = 1'b1;
		{p2.ras_n, p2.cas_n, p2.we_n} = 3'h7;
		p2.bank_sel = 2'h0;
		p2.addr = 13'h0000;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		fork
			begin
				for (int i = 0; i < 4; i++) begin
					b = 2'($random(seed));
					req(SDDR_OPEN, b, 1'b0);
					req(SDDR_WRITE, b, 1'b0);
					req(SDDR_READ, b, 1'b0);
					req(SDDR_CLOSE, b, 1'b0);
					req(SDDR_OPEN, b, 1'b0);
					req(SDDR_WRITE, b, 1'b1);
					req(SDDR_OPEN, b, 1'b0);
					req(SDDR_READ, b, 1'b1);
				end
				req(SDDR_OPEN, 2'h1, 1'b0);
				req(SDDR_OPEN, 2'h2, 1'b0);
				req(SDDR_CLOSE, 2'h0, 1'b1);
				req(SDDR_REFRESH, 2'h0, 1'b0);
				req(SDDR_MODE, 2'h0, 1'b0);
				req(SDDR_OPEN, 2'h3, 1'b0);
			end
			begin
				for (int j = 0; j < 37; j++) begin
					s = SEQ[j];
					@(posedge clk);
					p2.cs_n <= 1'b0;
					{p2.ras_n, p2.cas_n, p2.we_n} <= PAT[s[6:4]];
					p2.bank_sel <= s[3:2];
					p2.addr <= {2'h0, s[1], 10'h000};
					q_ill.push_back(s[0]);
					q_bnk.push_back(s[3:2]);
				end
				@(posedge clk);
				p2.cs_n <= 1'b1;
			end
		join
		repeat (10) @(posedge clk);
		end_sim();
	end
endmodule

// [inc/sddr_defs.svh]
// constants for the ddr sdram bank-state model: pin patterns, timings
// assumes a single 100 MHz clock shared by controller and device ends
`ifndef SDDR_DEFS_SVH
`define SDDR_DEFS_SVH

`define SDDR_ADDR_W        13
`define SDDR_BANKS         4
`define SDDR_AUTOCLOSE_BIT 10

// {row strobe, column strobe, write enable} with chip select low
`define SDDR_PAT_NOP     3'h7
`define SDDR_PAT_READ    3'h5
`define SDDR_PAT_WRITE   3'h4
`define SDDR_PAT_OPEN    3'h3
`define SDDR_PAT_CLOSE   3'h2
`define SDDR_PAT_REFRESH 3'h1
`define SDDR_PAT_MODE    3'h0

// interval times in ns, then whole clock cycles rounded up
`define SDDR_CLK_NS                 10
`define SDDR_PRECHARGE_TIME_NS      15
`define SDDR_OPEN_TO_COLUMN_NS      15
`define SDDR_WRITE_RECOVERY_TIME_NS 15
`define SDDR_ROW_CYCLE_TIME_NS      60
`define SDDR_MODE_SET_CYCLE_TIME_NS 20
`define SDDR_CEIL(t) (((t) + `SDDR_CLK_NS - 1) / `SDDR_CLK_NS)
`define SDDR_RP_CYC  `SDDR_CEIL(`SDDR_PRECHARGE_TIME_NS)
`define SDDR_RCD_CYC `SDDR_CEIL(`SDDR_OPEN_TO_COLUMN_NS)
`define SDDR_WR_CYC  `SDDR_CEIL(`SDDR_WRITE_RECOVERY_TIME_NS)
`define SDDR_RC_CYC  `SDDR_CEIL(`SDDR_ROW_CYCLE_TIME_NS)
`define SDDR_MRD_CYC `SDDR_CEIL(`SDDR_MODE_SET_CYCLE_TIME_NS)

// burst length in beats; two beats per clock
`define SDDR_BURST_LEN 4
`define SDDR_BURST_CYC (`SDDR_BURST_LEN / 2)

`endif

// [inc/sddr_if.sv]
// command pins between the controller end and the device end
// assumes both ends sample on the rising edge of the shared clock
`include "sddr_defs.svh"
interface sddr_if (
	input wire logic clk
);
	logic                    cke;
	logic                    cs_n;
	logic                    ras_n;
	logic                    cas_n;
	logic                    we_n;
	logic [1:0]              bank_sel;
	logic [`SDDR_ADDR_W-1:0] addr;

	modport ctl (
		input  clk,
		output cke,
		output cs_n,
		output ras_n,
		output cas_n,
		output we_n,
		output bank_sel,
		output addr
	);

	modport dev (
		input clk,
		input cke,
		input cs_n,
		input ras_n,
		input cas_n,
		input we_n,
		input bank_sel,
		input addr
	);
endinterface

// [inc/sddr_pkg.sv]
// types and pin codecs shared by both ends of the command link
// assumes sddr_defs.svh is on the include path
package sddr_pkg;
	`include "sddr_defs.svh"

	typedef enum logic [2:0] {
		SDDR_DESEL,
		SDDR_NOP,
		SDDR_READ,
		SDDR_WRITE,
		SDDR_OPEN,
		SDDR_CLOSE,
		SDDR_REFRESH,
		SDDR_MODE
	} sddr_cmd_e;

	typedef enum logic [3:0] {
		SDDR_BK_IDLE,
		SDDR_BK_OPENING,
		SDDR_BK_ACTIVE,
		SDDR_BK_READ,
		SDDR_BK_WRITE,
		SDDR_BK_READ_AC,
		SDDR_BK_WRITE_AC,
		SDDR_BK_WREC,
		SDDR_BK_WREC_AC,
		SDDR_BK_CLOSING
	} sddr_bank_e;

	typedef enum logic [1:0] {
		SDDR_GL_IDLE,
		SDDR_GL_REFRESH,
		SDDR_GL_MODE,
		SDDR_GL_SELF
	} sddr_glob_e;

	// unlisted pattern (HHL) is read as a no-op
	function automatic sddr_cmd_e sddr_decode(logic cs_n, logic [2:0] pat);
		sddr_cmd_e c;
		c = SDDR_NOP;
		if (cs_n) begin
			c = SDDR_DESEL;
		end else begin
			case (pat)
				`SDDR_PAT_READ:    c = SDDR_READ;
				`SDDR_PAT_WRITE:   c = SDDR_WRITE;
				`SDDR_PAT_OPEN:    c = SDDR_OPEN;
				`SDDR_PAT_CLOSE:   c = SDDR_CLOSE;
				`SDDR_PAT_REFRESH: c = SDDR_REFRESH;
				`SDDR_PAT_MODE:    c = SDDR_MODE;
				default:           c = SDDR_NOP;
			endcase
		end
		return c;
	endfunction

	function automatic logic [2:0] sddr_pattern(sddr_cmd_e c);
		logic [2:0] p;
		p = `SDDR_PAT_NOP;
		case (c)
			SDDR_READ:    p = `SDDR_PAT_READ;
			SDDR_WRITE:   p = `SDDR_PAT_WRITE;
			SDDR_OPEN:    p = `SDDR_PAT_OPEN;
			SDDR_CLOSE:   p = `SDDR_PAT_CLOSE;
			SDDR_REFRESH: p = `SDDR_PAT_REFRESH;
			SDDR_MODE:    p = `SDDR_PAT_MODE;
			default:      p = `SDDR_PAT_NOP;
		endcase
		return p;
	endfunction
endpackage
